// >>> core/ccp_pkg.sv
// Constants and types shared by the core clock and power control block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package ccp_pkg;

    // Clock rate and regulator settle time
    localparam int          CLK_MHZ          = 50;
    localparam int          WAKE_SETTLE_US   = 100;
    localparam int          WAKE_SETTLE_CYC  = WAKE_SETTLE_US * CLK_MHZ;

    // Multiplier limits and reset value
    localparam logic [5:0]  MULT_RST         = 6'h0a;
    localparam logic [5:0]  MULT_MIN         = 6'h01;

    // Divider register reset values
    localparam logic [3:0]  SYS_SEL_RST      = 4'h5;
    localparam logic [1:0]  CORE_SEL_RST     = 2'h0;

    // Regulator control register layout
    localparam int          VREG_SW_LSB      = 0;
    localparam int          VREG_LVL_LSB     = 2;
    localparam int          VREG_BYP_BIT     = 6;
    localparam int          VREG_DIS_BIT     = 7;
    localparam logic [1:0]  VREG_SW_OFF      = 2'h0;
    localparam logic [1:0]  VREG_SW_RST      = 2'h3;
    // Level code n gives 0.8 V + n * 50 mV; code 8 is 1.2 V
    localparam int          VREG_BASE_MV     = 800;
    localparam int          VREG_STEP_MV     = 50;
    localparam logic [3:0]  VREG_LVL_MAX     = 4'h8;
    localparam logic [3:0]  VREG_LVL_RST     = 4'h8;

    // Power state machine
    typedef enum logic [2:0] {
        CCP_RUN   = 3'b001,
        CCP_HIBER = 3'b010,
        CCP_WAKE  = 3'b100
    } ccp_state_t;

endpackage : ccp_pkg

// >>> core/ccp_core_clock_power.sv
// Core clock dividers, PLL multiplier register and hibernate control
`timescale 1ns/1ps
`default_nettype none

module ccp_core_clock_power
    import ccp_pkg::*;
#(
    parameter int WAKE_CYC = ccp_pkg::WAKE_SETTLE_CYC
) (
    input  wire logic       clock,
    input  wire logic       reset_n,
    // Divider register write port
    input  wire logic       div_wr,
    input  wire logic [3:0] div_system_divide_select,
    input  wire logic [1:0] div_core_divide_select,
    // Dedicated multiplier change sequence
    input  wire logic       mult_unlock,
    input  wire logic       mult_wr,
    input  wire logic [5:0] mult_wdata,
    // Regulator control register write port
    input  wire logic       vreg_wr,
    input  wire logic [7:0] vreg_wdata,
    // Wakeup sources
    input  wire logic       wake_rtc,
    input  wire logic       wake_can,
    input  wire logic       wake_reset_pin,
    input  wire logic       wake_gpio,
    // Derived clock enables
    output logic            core_clock_en,
    output logic            system_clock_en,
    // Readback and analog controls
    output logic [3:0]      system_divide_select,
    output logic [1:0]      core_divide_select,
    output logic [5:0]      pll_multiplier,
    output logic            pll_relock,
    output logic [7:0]      regulator_control_reg,
    output logic            regulator_enable,
    output logic            internal_core_supply_on,
    output logic            pins_out_enable,
    output logic            hibernate,
    output logic            boot_start
);
    import ccp_pkg::*;

    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    // Core ratio code to divisor minus one
    function automatic logic [2:0] core_div_last(input logic [1:0] sel);
        core_div_last = 3'(({1'b0, 3'h1} << sel) - 4'h1);
    endfunction : core_div_last

    // Clamp a voltage level code to the top step
    function automatic logic [3:0] vlevel_clamp(input logic [3:0] code);
        vlevel_clamp = (code > VREG_LVL_MAX) ? VREG_LVL_MAX : code;
    endfunction : vlevel_clamp

    //--------------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------------
    ccp_state_t  state_q;
    logic [3:0]  sys_sel_q;
    logic [1:0]  core_sel_q;
    logic [3:0]  sys_cnt_q;
    logic [2:0]  core_cnt_q;
    logic [5:0]  mult_q;
    logic        unlock_q;
    logic        relock_q;
    logic [1:0]  vreg_sw_q;
    logic [3:0]  vreg_lvl_q;
    logic        vreg_byp_q;
    logic        vreg_dis_q;
    logic [31:0] settle_q;
    logic        boot_q;
    logic        any_wake;
    logic        clocks_run;
    logic        sys_wrap;
    logic        core_wrap;
    logic        in_run;
    logic        in_hiber;
    logic        mult_take;
    logic        sys_en_q;
    logic        core_en_q;
    logic        reg_en_q;
    logic        supply_on_q;
    logic        pins_oe_q;
    logic        hiber_q;

    // State decodes shared by several processes
    assign in_run     = (state_q == CCP_RUN);
    assign in_hiber   = (state_q == CCP_HIBER);
    assign any_wake   = wake_rtc | wake_can | wake_reset_pin | wake_gpio;
    // Clocks run only with core power up
    assign clocks_run = in_run;
    assign sys_wrap   = (sys_cnt_q >= sys_sel_q - 4'h1);
    assign core_wrap  = (core_cnt_q >= core_div_last(core_sel_q));

    //--------------------------------------------------------------------------
    // Power state machine
    //--------------------------------------------------------------------------
    // Hibernate on switch field 00, wake on any source, then boot
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q  <= CCP_RUN;
            settle_q <= 32'h0;
            boot_q   <= 1'b0;
        end else begin
            boot_q <= 1'b0;
            case (state_q)
                CCP_RUN: begin
                    if (vreg_wr && vreg_wdata[VREG_SW_LSB +: 2] == VREG_SW_OFF) begin
                        state_q <= CCP_HIBER;
                    end
                end
                CCP_HIBER: begin
                    if (any_wake) begin
                        state_q  <= CCP_WAKE;
                        settle_q <= 32'h0;
                    end
                end
                CCP_WAKE: begin
                    // Hold clocks off until the regulator output settles
                    if (settle_q >= 32'(WAKE_CYC - 1)) begin
                        state_q <= CCP_RUN;
                        boot_q  <= 1'b1;
                    end else begin
                        settle_q <= settle_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= CCP_RUN;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // Regulator control register
    //--------------------------------------------------------------------------
    // Switch field returns to its reset value on wakeup so the supply stays up
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            vreg_sw_q  <= VREG_SW_RST;
            vreg_lvl_q <= VREG_LVL_RST;
            vreg_byp_q <= 1'b0;
            vreg_dis_q <= 1'b0;
        end else if (state_q == CCP_HIBER && any_wake) begin
            vreg_sw_q <= VREG_SW_RST;
        end else if (vreg_wr && state_q == CCP_RUN) begin
            vreg_sw_q  <= vreg_wdata[VREG_SW_LSB +: 2];
            vreg_lvl_q <= vlevel_clamp(vreg_wdata[VREG_LVL_LSB +: 4]);
            vreg_byp_q <= vreg_wdata[VREG_BYP_BIT];
            vreg_dis_q <= vreg_wdata[VREG_DIS_BIT];
        end
    end

    //--------------------------------------------------------------------------
    // Divider register
    //--------------------------------------------------------------------------
    // Reserved system code 0000 is dropped so the divider never stalls
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sys_sel_q  <= SYS_SEL_RST;
            core_sel_q <= CORE_SEL_RST;
        end else if (div_wr) begin
            if (div_system_divide_select != 4'h0) begin
                sys_sel_q <= div_system_divide_select;
            end
            core_sel_q <= div_core_divide_select;
        end
    end

    //--------------------------------------------------------------------------
    // System divider
    //--------------------------------------------------------------------------
    // Counter compares against the live select, so no relock is needed
    always_ff @(posedge clock) begin
        if (!reset_n || !clocks_run) begin
            sys_cnt_q <= 4'h0;
        end else if (sys_wrap) begin
            sys_cnt_q <= 4'h0;
        end else begin
            sys_cnt_q <= sys_cnt_q + 4'h1;
        end
    end

    //--------------------------------------------------------------------------
    // Core divider
    //--------------------------------------------------------------------------
    // A shrinking ratio wraps at once instead of counting past the end
    always_ff @(posedge clock) begin
        if (!reset_n || !clocks_run) begin
            core_cnt_q <= 3'h0;
        end else if (core_wrap) begin
            core_cnt_q <= 3'h0;
        end else begin
            core_cnt_q <= core_cnt_q + 3'h1;
        end
    end

    //--------------------------------------------------------------------------
    // Clock enable outputs
    //--------------------------------------------------------------------------
    // System enable; every peripheral shares it, so a divider change hits all at once
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            sys_en_q <= 1'b0;
        end else begin
            sys_en_q <= clocks_run && sys_wrap;
        end
    end

    // Core enable from the same input clock as the system one
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            core_en_q <= 1'b0;
        end else begin
            core_en_q <= clocks_run && core_wrap;
        end
    end

    //--------------------------------------------------------------------------
    // PLL multiplier
    //--------------------------------------------------------------------------
    // Unlock must come the cycle before the write; a lone write is ignored
    assign mult_take = mult_wr && unlock_q && (mult_wdata >= MULT_MIN);

    // First step of the change sequence, remembered for one cycle only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            unlock_q <= 1'b0;
        end else begin
            unlock_q <= mult_unlock;
        end
    end

    // Zero is refused so the oscillator is never asked to stop
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            mult_q <= MULT_RST;
        end else if (mult_take) begin
            mult_q <= mult_wdata;
        end
    end

    // One-cycle relock request to the analog loop after an accepted change
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            relock_q <= 1'b0;
        end else begin
            relock_q <= mult_take;
        end
    end

    //--------------------------------------------------------------------------
    // Power and pin outputs
    //--------------------------------------------------------------------------
    // Bypass or disable hand the supply to an external source
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            reg_en_q <= 1'b1;
        end else begin
            reg_en_q <= !in_hiber && !vreg_byp_q && !vreg_dis_q;
        end
    end

    // Core supply drops only in hibernate; bypass still counts as powered
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            supply_on_q <= 1'b1;
        end else begin
            supply_on_q <= !in_hiber;
        end
    end

    // Pins stay off through the wake settle so nothing drives before boot
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pins_oe_q <= 1'b1;
        end else begin
            pins_oe_q <= in_run;
        end
    end

    // Hibernate flag for the pad ring and the wakeup logic
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hiber_q <= 1'b0;
        end else begin
            hiber_q <= in_hiber;
        end
    end

    // Register readback and registered outputs
    assign system_divide_select    = sys_sel_q;
    assign core_divide_select      = core_sel_q;
    assign pll_multiplier          = mult_q;
    assign pll_relock              = relock_q;
    assign regulator_control_reg   = {vreg_dis_q, vreg_byp_q, vreg_lvl_q, vreg_sw_q};
    assign boot_start              = boot_q;
    assign system_clock_en         = sys_en_q;
    assign core_clock_en           = core_en_q;
    assign regulator_enable        = reg_en_q;
    assign internal_core_supply_on = supply_on_q;
    assign pins_out_enable         = pins_oe_q;
    assign hibernate               = hiber_q;

endmodule : ccp_core_clock_power

`default_nettype wire

// >>> tb/ccp_checker.sv
// Port-level assertions for the core clock and power control block
`timescale 1ns/1ps
`default_nettype none

module ccp_checker #(
    parameter int WAKE_CYC = 4
) (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       div_wr,
    input wire logic [3:0] div_system_divide_select,
    input wire logic [1:0] div_core_divide_select,
    input wire logic       mult_unlock,
    input wire logic       mult_wr,
    input wire logic [5:0] mult_wdata,
    input wire logic       vreg_wr,
    input wire logic [7:0] vreg_wdata,
    input wire logic       wake_rtc,
    input wire logic       wake_can,
    input wire logic       wake_reset_pin,
    input wire logic       wake_gpio,
    input wire logic       core_clock_en,
    input wire logic       system_clock_en,
    input wire logic [3:0] system_divide_select,
    input wire logic [1:0] core_divide_select,
    input wire logic [5:0] pll_multiplier,
    input wire logic       pll_relock,
    input wire logic       regulator_enable,
    input wire logic       internal_core_supply_on,
    input wire logic       pins_out_enable,
    input wire logic       hibernate,
    input wire logic       boot_start
);
    // All checks share the one clock and its reset
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    AST_RELOCK_CAUSE: assert property (
        pll_relock |-> $past(mult_wr) && $past(mult_unlock, 2) && pll_multiplier == $past(mult_wdata))
        else $error("relock without a full unlock and write");
    AST_MULT_HOLD: assert property (
        !$past(mult_wr) |-> $stable(pll_multiplier)) else $error("multiplier moved without a write");
    AST_DIV_LOAD: assert property (
        div_wr && div_system_divide_select != 4'h0 |=> system_divide_select == $past(div_system_divide_select)
        && core_divide_select == $past(div_core_divide_select)) else $error("divider write not loaded");
    AST_SYS_ZERO: assert property (
        div_wr && div_system_divide_select == 4'h0 |=> $stable(system_divide_select))
        else $error("zero system divisor accepted");
    AST_SYS_ONE: assert property (
        (system_divide_select == 4'h1 && pins_out_enable) [*3] |-> system_clock_en)
        else $error("divisor one not constant");
    AST_HIB_OFF: assert property (
        hibernate |-> !(internal_core_supply_on || regulator_enable || pins_out_enable
        || core_clock_en || system_clock_en)) else $error("hibernate left something on");
    AST_HIB_ENTRY: assert property (
        vreg_wr && vreg_wdata[1:0] == 2'h0 && pins_out_enable && !hibernate |-> ##2 hibernate)
        else $error("switch off write did not hibernate");
    AST_WAKE_BOOT: assert property (
        hibernate && (wake_rtc || wake_can || wake_reset_pin || wake_gpio) |-> ##[1:40] boot_start)
        else $error("wakeup gave no boot");
    AST_BOOT_PINS: assert property (
        boot_start |-> !hibernate ##[1:2] pins_out_enable) else $error("pins not back after boot");

    // Main scenarios reached
    cover property (pll_relock);
    cover property (hibernate ##1 !hibernate);
    cover property (boot_start);
endmodule : ccp_checker

bind ccp_core_clock_power ccp_checker #(.WAKE_CYC(WAKE_CYC)) u_ccp_checker (
    .clock                   (clock),
    .reset_n                 (reset_n),
    .div_wr                  (div_wr),
    .div_system_divide_select(div_system_divide_select),
    .div_core_divide_select  (div_core_divide_select),
    .mult_unlock             (mult_unlock),
    .mult_wr                 (mult_wr),
    .mult_wdata              (mult_wdata),
    .vreg_wr                 (vreg_wr),
    .vreg_wdata              (vreg_wdata),
    .wake_rtc                (wake_rtc),
    .wake_can                (wake_can),
    .wake_reset_pin          (wake_reset_pin),
    .wake_gpio               (wake_gpio),
    .core_clock_en           (core_clock_en),
    .system_clock_en         (system_clock_en),
    .system_divide_select    (system_divide_select),
    .core_divide_select      (core_divide_select),
    .pll_multiplier          (pll_multiplier),
    .pll_relock              (pll_relock),
    .regulator_enable        (regulator_enable),
    .internal_core_supply_on (internal_core_supply_on),
    .pins_out_enable         (pins_out_enable),
    .hibernate               (hibernate),
    .boot_start              (boot_start)
);

`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the core clock and power control block
`timescale 1ns/1ps
`default_nettype none

module tb;
    import ccp_pkg::*;
    logic       clock = 0, reset_n = 0, div_wr = 0, mult_unlock = 0, mult_wr = 0, vreg_wr = 0;
    logic       wake_rtc = 0, wake_can = 0, wake_reset_pin = 0, wake_gpio = 0;
    logic [3:0] div_system_divide_select = 4'h1;
    logic [1:0] div_core_divide_select = 2'h0;
    logic [5:0] mult_wdata = 6'h00;
    logic [7:0] vreg_wdata = 8'h00;
    logic       core_clock_en, system_clock_en, pll_relock, regulator_enable, internal_core_supply_on;
    logic       pins_out_enable, hibernate, boot_start;
    logic [3:0] system_divide_select;
    logic [1:0] core_divide_select;
    logic [5:0] pll_multiplier;
    logic [7:0] regulator_control_reg;
    int         num_errors = 0, checks_done = 0, cycles = 0, n;
    // Rows: {system code, core code}, and multiplier writes with the value each should leave
    logic [5:0] rows [4] = '{6'h04, 6'h19, 6'h2a, 6'h3f};
    logic [5:0] md [4] = '{6'd20, 6'd0, 6'd63, 6'd1};
    logic [5:0] me [4] = '{6'd20, 6'd20, 6'd63, 6'd1};

    // Short settle count keeps each wakeup quick
    ccp_core_clock_power #(.WAKE_CYC(4)) u_ccp_core_clock_power (
        .clock                   (clock),
        .reset_n                 (reset_n),
        .div_wr                  (div_wr),
        .div_system_divide_select(div_system_divide_select),
        .div_core_divide_select  (div_core_divide_select),
        .mult_unlock             (mult_unlock),
        .mult_wr                 (mult_wr),
        .mult_wdata              (mult_wdata),
        .vreg_wr                 (vreg_wr),
        .vreg_wdata              (vreg_wdata),
        .wake_rtc                (wake_rtc),
        .wake_can                (wake_can),
        .wake_reset_pin          (wake_reset_pin),
        .wake_gpio               (wake_gpio),
        .core_clock_en           (core_clock_en),
        .system_clock_en         (system_clock_en),
        .system_divide_select    (system_divide_select),
        .core_divide_select      (core_divide_select),
        .pll_multiplier          (pll_multiplier),
        .pll_relock              (pll_relock),
        .regulator_control_reg   (regulator_control_reg),
        .regulator_enable        (regulator_enable),
        .internal_core_supply_on (internal_core_supply_on),
        .pins_out_enable         (pins_out_enable),
        .hibernate               (hibernate),
        .boot_start              (boot_start)
    );

    always #10 clock = ~clock;

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic tick(input int k = 1);
        repeat (k) @(posedge clock);
        #1;
    endtask : tick

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Cycles from one enable pulse to the next, bounded so a dead enable cannot hang
    task automatic gap(input bit sys, output int g);
        int t;
        t = 0;
        while (!(sys ? system_clock_en : core_clock_en) && t < 40) begin
            tick();
            t++;
        end
        tick();
        g = 1;
        while (!(sys ? system_clock_en : core_clock_en) && g < 40) begin
            tick();
            g++;
        end
    endtask : gap

    task automatic vwr(input logic [7:0] d);
        vreg_wr = 1;
        vreg_wdata = d;
        tick();
        vreg_wr = 0;
        // Let an edge pass so a following write starts a fresh strobe
        tick();
    endtask : vwr

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    initial begin
        tick(8);
        reset_n = 1;
        chk("multiplier", 8'd10, pll_multiplier);
        chk("system select", 8'h05, system_divide_select);
        chk("regulator reg", 8'h23, regulator_control_reg);
        chk("power levels", 8'h03, {hibernate, pins_out_enable, internal_core_supply_on});
        $display("test reset done");
        // Divider table: readback, then measured periods of both enables
        foreach (rows[i]) begin
            div_wr = 1;
            {div_system_divide_select, div_core_divide_select} = rows[i];
            tick();
            div_wr = 0;
            chk("system select", rows[i][5:2], system_divide_select);
            chk("no relock", 8'h00, pll_relock);
            gap(1, n);
            chk("system period", rows[i][5:2], 8'(n));
            gap(0, n);
            chk("core period", 8'h1 << rows[i][1:0], 8'(n));
        end
        div_wr = 1;
        div_system_divide_select = 4'h0;
        div_core_divide_select = 2'h1;
        tick();
        div_wr = 0;
        chk("system kept", 8'h0f, system_divide_select);
        chk("core select", 8'h01, core_divide_select);
        $display("test dividers done");
        // A lone write must be ignored; only unlock then write counts
        mult_wr = 1;
        mult_wdata = 6'd33;
        tick();
        mult_wr = 0;
        tick();
        chk("lone write", 8'd10, pll_multiplier);
        foreach (md[i]) begin
            mult_unlock = 1;
            tick();
            mult_unlock = 0;
            mult_wr = 1;
            mult_wdata = md[i];
            tick();
            mult_wr = 0;
            chk("multiplier", me[i], pll_multiplier);
            chk("relock", 8'(md[i] != 6'd0), pll_relock);
            tick();
        end
        $display("test multiplier done");
        vwr(8'h0f);
        chk("regulator reg", 8'h0f, regulator_control_reg);
        vwr(8'h3f);
        chk("level clamp", 8'h23, regulator_control_reg);
        vwr(8'h63);
        tick(2);
        chk("bypass", 8'h01, {regulator_enable, internal_core_supply_on});
        vwr(8'ha3);
        tick(2);
        chk("disable", 8'h01, {regulator_enable, internal_core_supply_on});
        vwr(8'h23);
        tick(2);
        chk("regulator on", 8'h03, {regulator_enable, internal_core_supply_on});
        $display("test regulator done");
        // Hibernate and leave it once through each wakeup source
        for (int k = 0; k < 4; k++) begin
            vwr(8'h20);
            tick();
            chk("hibernate", 8'h08, {hibernate, internal_core_supply_on, pins_out_enable, regulator_enable});
            vwr(8'h23);
            chk("write in hibernate", 8'h20, regulator_control_reg);
            {wake_rtc, wake_can, wake_reset_pin, wake_gpio} = 4'h8 >> k;
            n = 0;
            while (!boot_start && n < 40) begin
                tick();
                n++;
            end
            {wake_rtc, wake_can, wake_reset_pin, wake_gpio} = 4'h0;
            chk("boot", 8'h01, boot_start);
            tick(2);
            chk("awake", 8'h03, {hibernate, pins_out_enable, internal_core_supply_on});
            chk("awake reg", 8'h23, regulator_control_reg);
        end
        $display("test hibernate done");
        // Reset in mid-run brings back the multiplier and divider defaults
        reset_n = 0;
        tick(2);
        reset_n = 1;
        chk("multiplier", 8'd10, pll_multiplier);
        chk("system select", 8'h05, system_divide_select);
        chk("core select", 8'h00, core_divide_select);
        $display("test mid reset done");
        end_sim();
    end
endmodule : tb

`default_nettype wire
